// ==== include/bytim_pkg.sv ====
// package for the byte timer: register map, fields, reset values and prescaler counts
package bytim_pkg;

	// register indexes; the byte address is four times the index
	localparam logic [7:0] IDX_CONTROL_TWO   = 8'h3c;
	localparam logic [7:0] IDX_CONTROL_ONE   = 8'h3d;
	localparam logic [7:0] IDX_TIMER_STATUS  = 8'h3e;
	localparam logic [7:0] IDX_FIRST_CAPTURE = 8'h3f;
	localparam logic [7:0] IDX_FIRST_COMPARE = 8'h40;
	localparam logic [7:0] IDX_COUNT         = 8'h41;
	localparam logic [7:0] IDX_ALT_COUNT     = 8'h42;
	localparam logic [7:0] IDX_SECOND_CAPT   = 8'h43;
	localparam logic [7:0] IDX_SECOND_COMP   = 8'h44;
	localparam int         ADDR_W            = 10;

	// control_one fields
	localparam int C1_CAP_IRQ_EN   = 7;
	localparam int C1_CMP_IRQ_EN   = 6;
	localparam int C1_OVF_IRQ_EN   = 5;
	localparam int C1_FORCE_SECOND = 4;
	localparam int C1_FORCE_FIRST  = 3;
	localparam int C1_SECOND_LEVEL = 2;
	localparam int C1_FIRST_EDGE   = 1;
	localparam int C1_FIRST_LEVEL  = 0;

	// control_two fields
	localparam int C2_FIRST_PIN_EN  = 7;
	localparam int C2_SECOND_PIN_EN = 6;
	localparam int C2_SINGLE_PULSE  = 5;
	localparam int C2_PWM           = 4;
	localparam int C2_CLK_SEL_HI    = 3;
	localparam int C2_CLK_SEL_LO    = 2;
	localparam int C2_SECOND_EDGE   = 1;

	// timer_status fields
	localparam int ST_FIRST_CAP   = 7;
	localparam int ST_FIRST_CMP   = 6;
	localparam int ST_OVERFLOW    = 5;
	localparam int ST_SECOND_CAP  = 4;
	localparam int ST_SECOND_CMP  = 3;
	localparam int ST_FREEZE      = 2;

	// writable masks: reserved bits read as zero
	localparam logic [7:0] CONTROL_TWO_MASK = 8'hfe;
	localparam logic [7:0] STATUS_WR_MASK   = 8'h04;

	// reset values and counter limits
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'hfc;
	localparam logic [7:0] COUNT_MAX     = 8'hff;
	localparam logic [7:0] COUNT_WRAP    = 8'h00;

	// prescaler: divide ratios of the counter clock
	localparam int         CPU_DIV_A     = 4;
	localparam int         CPU_DIV_B     = 2;
	localparam int         CPU_DIV_C     = 8;
	localparam int         OSC_DIV       = 8000;
	localparam int         PRE_W         = 13;
	localparam logic [1:0] CLK_SEL_DIV4  = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV2  = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV8  = 2'h2;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// bus channel state
	typedef enum logic [1:0] {
		BYTIM_IDLE  = 2'b00,
		BYTIM_WRESP = 2'b01,
		BYTIM_RRESP = 2'b10
	} bytim_bus_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awAddr;
		logic              awHeld;
		logic [31:0]       wData;
		logic [3:0]        wStrb;
		logic              wHeld;
		bytim_bus_t        wState;
		logic [1:0]        bResp;
		bytim_bus_t        rState;
		logic [31:0]       rData;
		logic [1:0]        rResp;
		logic [7:0]        controlOne;
		logic [7:0]        controlTwo;
		logic [7:0]        flags;
		logic [7:0]        armed;
		logic              freeze;
		logic [7:0]        firstCapture;
		logic [7:0]        secondCapture;
		logic [7:0]        firstCompare;
		logic [7:0]        secondCompare;
		logic [7:0]        firstCmpLive;
		logic [7:0]        secondCmpLive;
		logic [7:0]        count;
		logic [PRE_W-1:0]  presc;
		logic              firstCapPrev;
		logic              secondCapPrev;
		logic              firstPinLvl;
		logic              secondPinLvl;
	} bytim_state_t;

endpackage : bytim_pkg

// ==== design/bytim_timer.sv ====
// byte capture/compare timer with axi4-lite register slave
//
// Operation
// RULE_01: capture flags raise interrupt when capture enabled
// RULE_02: compare flags raise interrupt when compare enabled
// RULE_03: overflow flag raises interrupt when overflow enabled
// RULE_04: all events merge, gated by global mask
// RULE_05: events wake from wait, never halt
// RULE_06: force second output drives second pin
// RULE_07: force first output drives first pin
// RULE_08: second match puts second level out
// RULE_09: first match copies first level out
// RULE_10: edge bit: zero falling, one rising
// RULE_11: pin enables only route pins out
// RULE_12: single pulse triggered by first capture edge
// RULE_13: pwm: width first compare, period second
// RULE_14: clock select picks four prescale ratios
// RULE_15: first capture flag set, two-step clear
// RULE_16: first compare flag set, two-step clear
// RULE_17: overflow flag on wrap, alternate ignored
// RULE_18: second capture flag set, two-step clear
// RULE_19: second compare flag set, two-step clear
// RULE_20: freeze stops prescaler, counter and outputs
// RULE_21: counter resets fch, write resets it
// RULE_22: captures load live count, undefined reset
// RULE_23: software keeps reserved bits zero
// RULE_24: counter increments per tick, wraps
// RULE_25: pwm second match reloads counter fch
`timescale 1ns/1ps
`default_nettype none
module bytim_timer
	import bytim_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              clkEn,
	input  wire logic              oscTick,
	input  wire logic              globalMask,
	input  wire logic              haltMode,
	input  wire logic              firstCapturePin,
	input  wire logic              secondCapturePin,
	output logic                   firstComparePin,
	output logic                   firstComparePinOe,
	output logic                   secondComparePin,
	output logic                   secondComparePinOe,
	output logic                   timerIrq,
	output logic                   waitWake,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	bytim_state_t s_r;
	bytim_state_t s_nxt;
	logic         rstSync1_r;
	logic         rstSync2_r;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
		regAddr = {idx, 2'b00};
	endfunction : regAddr

	// prescale terminal count for a clock select value
	function automatic logic [PRE_W-1:0] divLast(input logic [1:0] sel);
		case (sel)
			CLK_SEL_DIV4: divLast = PRE_W'(CPU_DIV_A - 1);
			CLK_SEL_DIV2: divLast = PRE_W'(CPU_DIV_B - 1);
			CLK_SEL_DIV8: divLast = PRE_W'(CPU_DIV_C - 1);
			default:      divLast = PRE_W'(OSC_DIV - 1);
		endcase
	endfunction : divLast

	// edge detect honouring the edge-select bit
	function automatic logic edgeSeen(input logic rising, input logic prev, input logic cur);
		edgeSeen = rising ? (!prev && cur) : (prev && !cur);
	endfunction : edgeSeen

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end

	// next-state logic
	always_comb begin
		logic              awGo;
		logic              arGo;
		logic              wrNow;
		logic [ADDR_W-1:0] wrA;
		logic [7:0]        wrB;
		logic              rdNow;
		logic [ADDR_W-1:0] rdA;
		logic              mapped;
		logic [7:0]        rdB;
		logic              pwm;
		logic              single;
		logic              tick;
		logic              cap1Edge;
		logic              cap2Edge;
		logic              match1;
		logic              match2;
		logic              wrap;
		logic [7:0]        setF;
		logic [7:0]        clrF;
		logic              cntReset;
		logic              statusRead;
		awGo       = 1'b0;
		arGo       = 1'b0;
		wrNow      = 1'b0;
		wrA        = '0;
		wrB        = '0;
		rdNow      = 1'b0;
		rdA        = '0;
		mapped     = 1'b0;
		rdB        = '0;
		setF       = '0;
		clrF       = '0;
		cntReset   = 1'b0;
		statusRead = 1'b0;
		s_nxt      = s_r;
		pwm        = s_r.controlTwo[C2_PWM];
		single     = s_r.controlTwo[C2_SINGLE_PULSE] && !pwm;

		// write channel capture, address and data in either order
		if (s_axi_awvalid && !s_r.awHeld && s_r.wState == BYTIM_IDLE) begin
			s_nxt.awAddr = s_axi_awaddr;
			s_nxt.awHeld = 1'b1;
		end
		if (s_axi_wvalid && !s_r.wHeld && s_r.wState == BYTIM_IDLE) begin
			s_nxt.wData = s_axi_wdata;
			s_nxt.wStrb = s_axi_wstrb;
			s_nxt.wHeld = 1'b1;
		end
		if (s_r.awHeld && s_r.wHeld && s_r.wState == BYTIM_IDLE) begin
			wrNow        = s_r.wStrb[0];
			wrA          = s_r.awAddr;
			wrB          = s_r.wData[7:0];
			s_nxt.awHeld = 1'b0;
			s_nxt.wHeld  = 1'b0;
			s_nxt.wState = BYTIM_WRESP;
			awGo         = 1'b1;
			case (s_r.awAddr)
				regAddr(IDX_CONTROL_TWO), regAddr(IDX_CONTROL_ONE), regAddr(IDX_TIMER_STATUS),
				regAddr(IDX_FIRST_CAPTURE), regAddr(IDX_FIRST_COMPARE), regAddr(IDX_COUNT),
				regAddr(IDX_ALT_COUNT), regAddr(IDX_SECOND_CAPT), regAddr(IDX_SECOND_COMP):
					s_nxt.bResp = RESP_OKAY;
				default: s_nxt.bResp = RESP_SLVERR;
			endcase
		end
		if (s_r.wState == BYTIM_WRESP && s_axi_bready) begin
			s_nxt.wState = BYTIM_IDLE;
		end

		// read channel
		if (s_axi_arvalid && s_r.rState == BYTIM_IDLE) begin
			arGo         = 1'b1;
			rdNow        = 1'b1;
			rdA          = s_axi_araddr;
			s_nxt.rState = BYTIM_RRESP;
		end
		if (s_r.rState == BYTIM_RRESP && s_axi_rready) begin
			s_nxt.rState = BYTIM_IDLE;
		end
		// read mux; reserved bits read zero
		mapped = 1'b1;
		case (rdA)
			regAddr(IDX_CONTROL_TWO):   rdB = s_r.controlTwo;
			regAddr(IDX_CONTROL_ONE):   rdB = s_r.controlOne;
			regAddr(IDX_TIMER_STATUS):  rdB = {s_r.flags[7:3], s_r.freeze, 2'b00};
			regAddr(IDX_FIRST_CAPTURE): rdB = s_r.firstCapture;
			regAddr(IDX_FIRST_COMPARE): rdB = s_r.firstCompare;
			// RULE_21: both counters read live
			regAddr(IDX_COUNT), regAddr(IDX_ALT_COUNT): rdB = s_r.count;
			regAddr(IDX_SECOND_CAPT):   rdB = s_r.secondCapture;
			regAddr(IDX_SECOND_COMP):   rdB = s_r.secondCompare;
			default: begin
				rdB    = '0;
				mapped = 1'b0;
			end
		endcase
		if (rdNow) begin
			s_nxt.rData = {24'h000000, rdB};
			s_nxt.rResp = mapped ? RESP_OKAY : RESP_SLVERR;
		end

		// register writes; RULE_20 keeps the writable registers writable while frozen
		if (wrNow) begin
			case (wrA)
				regAddr(IDX_CONTROL_ONE): s_nxt.controlOne = wrB;
				// RULE_23 reserved bit forced low regardless of software
				regAddr(IDX_CONTROL_TWO): s_nxt.controlTwo = wrB & CONTROL_TWO_MASK;
				regAddr(IDX_TIMER_STATUS): s_nxt.freeze = wrB[ST_FREEZE];
				regAddr(IDX_FIRST_COMPARE): s_nxt.firstCompare = wrB;
				regAddr(IDX_SECOND_COMP): s_nxt.secondCompare = wrB;
				// RULE_21 write resets counter
				regAddr(IDX_COUNT), regAddr(IDX_ALT_COUNT): cntReset = 1'b1;
				default: ;
			endcase
		end

		// two-step clear: status read arms set flags, next matching access clears
		statusRead = rdNow && rdA == regAddr(IDX_TIMER_STATUS);
		begin
			logic              acc;
			logic [ADDR_W-1:0] accA;
			acc  = rdNow || wrNow;
			accA = rdNow ? rdA : wrA;
			if (acc) begin
				case (accA)
					// RULE_15 first capture access
					regAddr(IDX_FIRST_CAPTURE): clrF[ST_FIRST_CAP] = s_r.armed[ST_FIRST_CAP];
					// RULE_16 first compare access
					regAddr(IDX_FIRST_COMPARE): clrF[ST_FIRST_CMP] = s_r.armed[ST_FIRST_CMP];
					// RULE_17 only the main counter clears overflow
					regAddr(IDX_COUNT): clrF[ST_OVERFLOW] = s_r.armed[ST_OVERFLOW];
					// RULE_18 second capture access
					regAddr(IDX_SECOND_CAPT): clrF[ST_SECOND_CAP] = s_r.armed[ST_SECOND_CAP];
					// RULE_19 second compare access
					regAddr(IDX_SECOND_COMP): clrF[ST_SECOND_CMP] = s_r.armed[ST_SECOND_CMP];
					default: ;
				endcase
			end
		end

		// RULE_14 prescaler terminal count; RULE_20 freeze stops it
		tick = 1'b0;
		if (!s_r.freeze) begin
			if (s_r.controlTwo[C2_CLK_SEL_HI] && s_r.controlTwo[C2_CLK_SEL_LO]) begin
				// oscillator path: count oscillator ticks, not cpu cycles
				if (oscTick) begin
					if (s_r.presc >= divLast(s_r.controlTwo[C2_CLK_SEL_HI:C2_CLK_SEL_LO])) begin
						s_nxt.presc = '0;
						tick        = 1'b1;
					end else begin
						s_nxt.presc = s_r.presc + PRE_W'(1);
					end
				end
			end else if (s_r.presc >= divLast(s_r.controlTwo[C2_CLK_SEL_HI:C2_CLK_SEL_LO])) begin
				s_nxt.presc = '0;
				tick        = 1'b1;
			end else begin
				s_nxt.presc = s_r.presc + PRE_W'(1);
			end
		end

		// RULE_10 edge select per capture pin
		cap1Edge = edgeSeen(s_r.controlOne[C1_FIRST_EDGE], s_r.firstCapPrev, firstCapturePin);
		cap2Edge = edgeSeen(s_r.controlTwo[C2_SECOND_EDGE], s_r.secondCapPrev, secondCapturePin);
		s_nxt.firstCapPrev  = firstCapturePin;
		s_nxt.secondCapPrev = secondCapturePin;

		// compares judged once per counter tick; RULE_11 independent of pin enables
		match1 = tick && s_r.count == (pwm ? s_r.firstCmpLive : s_r.firstCompare);
		match2 = tick && s_r.count == (pwm ? s_r.secondCmpLive : s_r.secondCompare);
		wrap   = tick && s_r.count == COUNT_MAX;

		// RULE_24 counter advances per tick and wraps
		if (tick) begin
			s_nxt.count = s_r.count + 8'h01;
		end
		// RULE_25 pwm period end reloads count; buffered compares take new values here
		if (pwm && match2) begin
			s_nxt.count         = COUNT_RESET;
			s_nxt.firstCmpLive  = s_r.firstCompare;
			s_nxt.secondCmpLive = s_r.secondCompare;
		end
		if (!pwm) begin
			s_nxt.firstCmpLive  = s_r.firstCompare;
			s_nxt.secondCmpLive = s_r.secondCompare;
		end
		// RULE_12 single pulse start on first capture edge
		if (single && cap1Edge) begin
			s_nxt.count       = COUNT_RESET;
			s_nxt.firstPinLvl = s_r.controlOne[C1_SECOND_LEVEL];
		end
		if (cntReset) begin
			s_nxt.count = COUNT_RESET;
		end

		// RULE_22 capture registers load live count
		if (cap1Edge && !pwm && !single) begin
			s_nxt.firstCapture = s_r.count;
		end
		if (cap2Edge) begin
			s_nxt.secondCapture = s_r.count;
		end

		// flag sources; compare flags withheld in pwm, first compare withheld in single pulse
		// RULE_15 first capture or pwm period end
		setF[ST_FIRST_CAP]  = (cap1Edge && !pwm) || (pwm && match2);
		// RULE_16 first compare match
		setF[ST_FIRST_CMP]  = match1 && !pwm && !single;
		// RULE_17 wrap from max to zero
		setF[ST_OVERFLOW]   = wrap && !(pwm && match2);
		// RULE_18 second capture edge
		setF[ST_SECOND_CAP] = cap2Edge;
		// RULE_19 second compare match
		setF[ST_SECOND_CMP] = match2 && !pwm;
		// hardware set wins over a clear in the same cycle
		s_nxt.flags = ((s_r.flags & ~clrF) | setF) & 8'hf8;
		if (statusRead) begin
			s_nxt.armed = s_r.flags & 8'hf8;
		end else begin
			s_nxt.armed = s_r.armed & ~clrF;
		end

		// output levels
		if (pwm) begin
			// RULE_13 pwm: first level at width, second level at period
			if (match1) begin
				s_nxt.firstPinLvl = s_r.controlOne[C1_FIRST_LEVEL];
			end
			// RULE_08 second level routed to first pin
			if (match2) begin
				s_nxt.firstPinLvl = s_r.controlOne[C1_SECOND_LEVEL];
			end
		end else if (single) begin
			// RULE_12 pulse ends at first compare value
			if (match1) begin
				s_nxt.firstPinLvl = s_r.controlOne[C1_FIRST_LEVEL];
			end
		end else begin
			// RULE_09 first match copies level
			if (match1) begin
				s_nxt.firstPinLvl = s_r.controlOne[C1_FIRST_LEVEL];
			end
			// RULE_08 second match copies level
			if (match2) begin
				s_nxt.secondPinLvl = s_r.controlOne[C1_SECOND_LEVEL];
			end
		end
		// RULE_07 forced first level
		if (s_r.controlOne[C1_FORCE_FIRST]) begin
			s_nxt.firstPinLvl = s_r.controlOne[C1_FIRST_LEVEL];
		end
		// RULE_06 forced second level
		if (s_r.controlOne[C1_FORCE_SECOND]) begin
			s_nxt.secondPinLvl = s_r.controlOne[C1_SECOND_LEVEL];
		end

		// bus handshakes are combinational
		s_axi_awready = awGo;
		s_axi_wready  = awGo;
		s_axi_arready = arGo;
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge clk or negedge rstSync2_r) begin
		if (!rstSync2_r) begin
			s_r            <= '0;
			s_r.controlOne <= CONTROL_RESET;
			s_r.controlTwo <= CONTROL_RESET;
			s_r.count      <= COUNT_RESET;
		end else if (clkEn) begin
			s_r <= s_nxt;
		end
	end

	// RULE_11 enables only hand pins over; RULE_20 freeze disables outputs
	assign firstComparePin    = s_r.firstPinLvl;
	assign secondComparePin   = s_r.secondPinLvl;
	assign firstComparePinOe  = !(s_r.controlTwo[C2_FIRST_PIN_EN] && !s_r.freeze);
	assign secondComparePinOe = !(s_r.controlTwo[C2_SECOND_PIN_EN] && !s_r.freeze);

	// RULE_01 RULE_02 RULE_03 RULE_04 merged request gated by global mask
	logic irqReq;
	assign irqReq = (s_r.controlOne[C1_CAP_IRQ_EN] && (s_r.flags[ST_FIRST_CAP] || s_r.flags[ST_SECOND_CAP]))
		|| (s_r.controlOne[C1_CMP_IRQ_EN] && (s_r.flags[ST_FIRST_CMP] || s_r.flags[ST_SECOND_CMP]))
		|| (s_r.controlOne[C1_OVF_IRQ_EN] && s_r.flags[ST_OVERFLOW]);
	assign timerIrq = irqReq && !globalMask;
	// RULE_05 wake from wait only, never from halt
	assign waitWake = irqReq && !haltMode;

	// axi answers from registered state
	assign s_axi_bvalid = s_r.wState == BYTIM_WRESP;
	assign s_axi_bresp  = s_r.bResp;
	assign s_axi_rvalid = s_r.rState == BYTIM_RRESP;
	assign s_axi_rdata  = s_r.rData;
	assign s_axi_rresp  = s_r.rResp;

endmodule : bytim_timer
`default_nettype wire

// ==== dv/bytim_pin_model.sv ====
// far-side pins: capture drivers and pulled-up compare lines
`timescale 1ns/1ps
`default_nettype none
module bytim_pin_model (
	input  wire logic clk,
	input  wire logic capReq1,
	input  wire logic capReq2,
	input  wire logic pin1,
	input  wire logic oe1,
	input  wire logic pin2,
	input  wire logic oe2,
	output logic      cap1,
	output logic      cap2,
	output logic      line1,
	output logic      line2
);
	// capture pins move on the clock so no edge is seen half-way
	always_ff @(posedge clk) begin
		cap1 <= capReq1;
		cap2 <= capReq2;
	end
	// a released compare line floats up through its pull-up
	assign line1 = oe1 ? 1'b1 : pin1;
	assign line2 = oe2 ? 1'b1 : pin2;
endmodule : bytim_pin_model
`default_nettype wire

// ==== dv/bytim_timer_chk.sv ====
// port checker for the byte timer, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module bytim_timer_chk
	import bytim_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        clkEn,
	input wire logic        globalMask,
	input wire logic        haltMode,
	input wire logic        timerIrq,
	input wire logic        waitWake,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	irq_masked_a: assert property (globalMask |-> !timerIrq)
		else $error("timer irq while masked");
	halt_no_wake_a: assert property (haltMode |-> !waitWake)
		else $error("wake raised in halt");
	wait_wake_a: assert property (timerIrq && !haltMode |-> waitWake)
		else $error("irq without wait wake");
	write_answer_a: assert property (s_axi_awready && s_axi_wready && clkEn |=> s_axi_bvalid)
		else $error("write not answered");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid)
		else $error("read not answered");
	bvalid_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready && s_axi_wready))
		else $error("write answer without request");
	rvalid_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
	rdata_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above one byte");
	slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returns data");
endmodule : bytim_timer_chk
bind bytim_timer bytim_timer_chk u_chk (.clk, .rstn, .clkEn, .globalMask, .haltMode, .timerIrq, .waitWake,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// ==== dv/bytim_timer_test.sv ====
// self-checking bench for the byte timer
`timescale 1ns/1ps
`default_nettype none
module bytim_timer_test
	import bytim_pkg::*;
;
	localparam logic [9:0] A_C2 = {IDX_CONTROL_TWO, 2'b00};
	localparam logic [9:0] A_C1 = {IDX_CONTROL_ONE, 2'b00};
	localparam logic [9:0] A_ST = {IDX_TIMER_STATUS, 2'b00};
	localparam logic [9:0] A_CP1 = {IDX_FIRST_CAPTURE, 2'b00};
	localparam logic [9:0] A_OC1 = {IDX_FIRST_COMPARE, 2'b00};
	localparam logic [9:0] A_CNT = {IDX_COUNT, 2'b00};
	localparam logic [9:0] A_ACT = {IDX_ALT_COUNT, 2'b00};
	localparam logic [9:0] A_CP2 = {IDX_SECOND_CAPT, 2'b00};
	localparam logic [9:0] A_OC2 = {IDX_SECOND_COMP, 2'b00};
	logic clk, rstn, clkEn, oscTick, globalMask, haltMode, capReq1, capReq2, cap1, cap2;
	logic pin1, oe1, pin2, oe2, line1, line2, timerIrq, waitWake;
	logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
	logic [9:0]  awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp;
	int          n_errors, tests_run;
	bytim_timer u_dut (.clk, .rstn, .clkEn, .oscTick, .globalMask, .haltMode,
		.firstCapturePin(cap1), .secondCapturePin(cap2), .firstComparePin(pin1), .firstComparePinOe(oe1),
		.secondComparePin(pin2), .secondComparePinOe(oe2), .timerIrq, .waitWake,
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady));
	bytim_pin_model u_pins (.clk, .capReq1, .capReq2, .pin1, .oe1, .pin2, .oe2, .cap1, .cap2, .line1, .line2);
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done
	// write: both channels offered together, each released once taken
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		logic ga, gw;
		ga = 1'b0;
		gw = 1'b0;
		@(posedge clk);
		awAddr <= a;
		wData <= {24'h0, v};
		wStrb <= 4'hf;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!(ga && gw)) begin
			@(negedge clk);
			if (awReady) ga = 1'b1;
			if (wReady) gw = 1'b1;
			@(posedge clk);
			if (ga) awValid <= 1'b0;
			if (gw) wValid <= 1'b0;
		end
		do @(negedge clk); while (!bValid);
		@(posedge clk);
		bReady <= 1'b0;
	endtask : wr
	// read: readiness sampled mid-cycle, so it is the value at the next edge
	task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do @(negedge clk); while (!arReady);
		@(posedge clk);
		arValid <= 1'b0;
		do @(negedge clk); while (!rValid);
		d = rData;
		r = rResp;
		@(posedge clk);
		rReady <= 1'b0;
	endtask : rd
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		logic [9:0]  al[4] = '{A_C1, A_C2, A_OC1, A_OC2};
		wr(A_ST, 8'h04);
		rd(A_ST, d, r);
		chk(d, 32'h04);
		foreach (al[i]) begin
			rd(al[i], d, r);
			chk(d, 32'h0);
		end
		wr(A_CNT, 8'h55);
		rd(A_CNT, d, r);
		chk(d, 32'hfc);
		wr(A_ACT, 8'h12);
		rd(A_ACT, d, r);
		chk(d, 32'hfc);
		wr(A_C2, 8'h0e);
		rd(A_C2, d, r);
		chk(d, 32'h0e);
		wr(10'h000, 8'h01);
		chk(32'(bResp), 32'(RESP_SLVERR));
		rd(10'h000, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		done("registers");
	endtask : t_regs
	task automatic t_prescale;
		logic [31:0] a, b;
		logic [1:0]  r;
		int          dv[3] = '{4, 2, 8};
		for (int i = 0; i < 3; i++) begin
			wr(A_C2, {4'h0, 2'(i), 2'b00});
			wr(A_ST, 8'h00);
			rd(A_CNT, a, r);
			repeat (40 * dv[i]) @(posedge clk);
			rd(A_CNT, b, r);
			chk(32'(8'(b - a) inside {[8'd40:8'd42]}), 32'h1);
		end
		wr(A_C2, 8'h0c);
		oscTick <= 1'b1;
		rd(A_CNT, a, r);
		repeat (16000) @(posedge clk);
		rd(A_CNT, b, r);
		oscTick <= 1'b0;
		chk(32'(8'(b - a) inside {[8'd1:8'd3]}), 32'h1);
		wr(A_ST, 8'h04);
		rd(A_CNT, a, r);
		repeat (100) @(posedge clk);
		rd(A_CNT, b, r);
		chk(b, a);
		done("prescaler");
	endtask : t_prescale
	task automatic t_overflow;
		logic [31:0] d;
		logic [1:0]  r;
		wr(A_C2, 8'h00);
		wr(A_CNT, 8'h00);
		wr(A_C1, 8'h00);
		wr(A_ST, 8'h00);
		repeat (40) @(posedge clk);
		rd(A_ST, d, r);
		chk(d, 32'h68);
		chk(32'(timerIrq), 32'h0);
		wr(A_C1, 8'h20);
		@(negedge clk);
		chk(32'({timerIrq, waitWake}), 32'h3);
		@(posedge clk);
		globalMask <= 1'b1;
		haltMode <= 1'b1;
		@(negedge clk);
		chk(32'({timerIrq, waitWake}), 32'h0);
		@(posedge clk);
		globalMask <= 1'b0;
		haltMode <= 1'b0;
		rd(A_ACT, d, r);
		rd(A_ST, d, r);
		chk(d, 32'h68);
		rd(A_CNT, d, r);
		rd(A_ST, d, r);
		chk(32'({d[5], timerIrq}), 32'h0);
		done("overflow");
	endtask : t_overflow
	task automatic t_capture;
		logic [31:0] d, a;
		logic [1:0]  r;
		wr(A_C1, 8'h80);
		wr(A_C2, 8'h02);
		@(posedge clk);
		capReq1 <= 1'b1;
		repeat (4) @(posedge clk);
		rd(A_ST, d, r);
		chk(d & 32'h90, 32'h0);
		rd(A_CNT, a, r);
		capReq1 <= 1'b0;
		repeat (4) @(posedge clk);
		rd(A_ST, d, r);
		chk(d & 32'h90, 32'h80);
		chk(32'(timerIrq), 32'h1);
		rd(A_CP1, d, r);
		chk(32'(8'(d - a) inside {[8'd0:8'd3]}), 32'h1);
		rd(A_ST, d, r);
		chk(d & 32'h90, 32'h0);
		capReq2 <= 1'b1;
		repeat (4) @(posedge clk);
		rd(A_ST, d, r);
		chk(d & 32'h90, 32'h10);
		rd(A_CP2, d, r);
		rd(A_ST, d, r);
		chk(d & 32'h90, 32'h0);
		done("capture");
	endtask : t_capture
	task automatic t_outputs;
		logic [31:0] d;
		logic [1:0]  r;
		wr(A_C2, 8'hc0);
		wr(A_C1, 8'h1d);
		@(negedge clk);
		chk(32'({oe1, oe2, line1, line2}), 32'h3);
		wr(A_C1, 8'h18);
		@(negedge clk);
		chk(32'({oe1, oe2, line1, line2}), 32'h0);
		wr(A_C2, 8'h00);
		@(negedge clk);
		chk(32'({oe1, oe2}), 32'h3);
		wr(A_C2, 8'hc0);
		wr(A_CNT, 8'h00);
		rd(A_ST, d, r);
		wr(A_OC1, 8'h10);
		wr(A_OC2, 8'h20);
		wr(A_C1, 8'h05);
		@(negedge clk);
		chk(32'({line1, line2}), 32'h0);
		repeat (150) @(posedge clk);
		@(negedge clk);
		chk(32'({oe1, oe2, line1, line2}), 32'h3);
		rd(A_ST, d, r);
		chk(d & 32'h48, 32'h48);
		wr(A_C1, 8'h45);
		@(negedge clk);
		chk(32'(timerIrq), 32'h1);
		wr(A_ST, 8'h04);
		@(negedge clk);
		chk(32'({oe1, oe2}), 32'h3);
		done("outputs");
	endtask : t_outputs
	task automatic t_pwm;
		logic [31:0] d;
		logic [1:0]  r;
		wr(A_C1, 8'h04);
		wr(A_OC1, 8'h20);
		wr(A_OC2, 8'h40);
		wr(A_C2, 8'h90);
		wr(A_CNT, 8'h00);
		wr(A_ST, 8'h00);
		repeat (8) begin
			repeat (37) @(posedge clk);
			rd(A_CNT, d, r);
			chk(32'(d[7:0] >= 8'hfc || d[7:0] <= 8'h40), 32'h1);
		end
		rd(A_ST, d, r);
		chk(d & 32'h80, 32'h80);
		wr(A_C2, 8'ha0);
		wr(A_C1, 8'h0b);
		wr(A_C1, 8'h03);
		capReq1 <= 1'b1;
		repeat (8) @(negedge clk);
		chk(32'(line1), 32'h0);
		repeat (200) @(negedge clk);
		chk(32'(line1), 32'h1);
		done("pwm");
	endtask : t_pwm
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// main sequence: reset two cycles, then the scenarios
	initial begin
		{rstn, oscTick, globalMask, haltMode, capReq1, capReq2} = 6'h0;
		{awValid, wValid, bReady, arValid, rReady} = 5'h0;
		clkEn = 1'b1;
		awAddr = 10'h0;
		arAddr = 10'h0;
		wData = 32'h0;
		wStrb = 4'h0;
		n_errors = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_prescale();
		t_overflow();
		t_capture();
		t_outputs();
		t_pwm();
		tally_and_finish();
	end
	// watchdog well past the roughly 18k cycles the run needs
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
endmodule : bytim_timer_test
`default_nettype wire
